/* File: rtl/sw_reset_pkg.sv */
// Purpose: Constants for the peripheral software reset controller
// Assumes: Avalon-MM slave, 32-bit data, byte addressing
// Notes:   Offsets are byte addresses within the system-control space
package sw_reset_pkg;
	localparam int          ADDR_W          = 12;
	localparam logic [11:0] PERIPH_RST_OFS  = 12'h044;
	localparam logic [11:0] PORT_RST_OFS    = 12'h048;
	localparam logic [11:0] PERIPH_CAP_OFS  = 12'h100;
	localparam logic [11:0] PORT_CAP_OFS    = 12'h104;
	localparam logic [31:0] PERIPH_RST_INIT = 32'h0000_0000;
	localparam logic [31:0] PORT_RST_INIT   = 32'h0000_0000;
	// Implemented bits of each reset register, all others reserved
	localparam logic [31:0] PERIPH_RST_IMPL = 32'h0705_1133;
	localparam logic [31:0] PORT_RST_IMPL   = 32'h0000_00ff;
	localparam logic [31:0] PERIPH_CAP_INIT = 32'h0705_1133;
	localparam logic [31:0] PORT_CAP_INIT   = 32'h0000_00ff;
	localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;
	localparam logic [31:0] READDATA_INIT   = 32'h0000_0000;
	// Field positions in the first reset register
	localparam int ASYNC0_BIT = 0;
	localparam int ASYNC1_BIT = 1;
	localparam int SYNC0_BIT  = 4;
	localparam int SYNC1_BIT  = 5;
	localparam int QUAD0_BIT = 8;
	localparam int TWI0_BIT  = 12;
	localparam int GPT0_BIT  = 16;
	localparam int CMP0_BIT  = 24;
endpackage

/* File: rtl/peripheral_software_reset_ctrl.sv */
// Purpose: Software reset bits for on-chip peripherals and I/O ports
// Assumes: Avalon-MM slave, one wait state per access unless ack_r is still set, clk_in at 100 MHz
// Notes:   Capability masks are software-writable registers of this block
//
// Behaviour
// - Port reset writes only change bits enabled in port capability mask.
// - Eight port reset bits: bit 0 is port A up to bit 7 port H.
// - Quadrature unit zero reset lives at bit 8 of first register.
// - Sync serial one and zero resets at bits 5 and 4.
// - Async serial one and zero resets at bits 1 and 0.
// - Reserved bits read zero; software writes back read values.
// - Port reset register at 0x048, cleared to zero at reset.
// - First register at 0x044, writes gated by peripheral capability mask.
// - Comparators at 26:24, counters at bits 18 and 16 (bit 17 reserved), two-wire unit at bit 12.
`timescale 1ns/10ps
`default_nettype none
module peripheral_software_reset_ctrl
	import sw_reset_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rst_b_in,
	input  wire logic              clk_en_in,
	input  wire logic [ADDR_W-1:0] address_in,
	input  wire logic              read_in,
	input  wire logic              write_in,
	input  wire logic [31:0]       writedata_in,
	input  wire logic [3:0]        byteenable_in,
	output logic [31:0]            readdata_out,
	output logic                   waitrequest_out,
	output logic                   async_serial_zero_reset_out,
	output logic                   async_serial_one_reset_out,
	output logic                   sync_serial_zero_reset_out,
	output logic                   sync_serial_one_reset_out,
	output logic                   quadrature_unit_zero_reset_out,
	output logic                   two_wire_zero_reset_out,
	output logic [2:0]             gp_counter_reset_out,
	output logic [2:0]             comparator_reset_out,
	output logic [7:0]             port_reset_out
);

	////////////////////////////////////////////////////////////////////////
	// Register state, one current and one next value per register
	logic [31:0] periph_rst_r;
	logic [31:0] periph_rst_nxt;
	logic [31:0] port_rst_r;
	logic [31:0] port_rst_nxt;
	logic [31:0] periph_cap_r;
	logic [31:0] periph_cap_nxt;
	logic [31:0] port_cap_r;
	logic [31:0] port_cap_nxt;
	logic [31:0] readdata_r;
	logic [31:0] readdata_nxt;
	logic        ack_r;
	logic        ack_nxt;

	// Bus decode, handshake and write-mask helpers
	logic [31:0] be_mask;
	logic        req;
	logic        take;
	logic        commit;
	logic        hit_periph_rst;
	logic        hit_port_rst;
	logic        hit_periph_cap;
	logic        hit_port_cap;
	logic [31:0] periph_wmask;
	logic [31:0] port_wmask;
	logic [31:0] periph_cap_wmask;
	logic [31:0] port_cap_wmask;
	logic [31:0] periph_rd;
	logic [31:0] port_rd;

	////////////////////////////////////////////////////////////////////////
	// Expand byte enables to a bit mask
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			be_mask[i*8 +: 8] = {8{byteenable_in[i]}};
		end
	end

	// Handshake: the first cycle of a request is a wait state unless ack_r is still set, and
	// the second completes it. Read data is captured in the wait cycle so
	// that it stands from a flop while waitrequest is low, and a write
	// lands only on the edge where the master sees waitrequest low.
	// A request dropped after its wait cycle still sets ack_r, so a request raised the next cycle gets no wait state.
	// Clock enable low with a request pending stretches the wait state,
	// so a master must not give up on a frozen block too soon.
	assign req             = read_in | write_in;
	assign take            = req & ~ack_r;     // Wait cycle
	assign commit          = write_in & ack_r; // Acknowledged edge
	assign waitrequest_out = take;

	// Address decode; every other address is unmapped and drops writes
	always_comb begin
		hit_periph_rst = (address_in == PERIPH_RST_OFS);
		hit_port_rst   = (address_in == PORT_RST_OFS);
		hit_periph_cap = (address_in == PERIPH_CAP_OFS);
		hit_port_cap   = (address_in == PORT_CAP_OFS);
	end

	// Bits a write may move: enabled lane, implemented and, for the reset registers, capable.
	// A capability bit of zero freezes its reset bit, so software cannot
	// disturb a unit that this part does not carry.
	always_comb begin
		periph_wmask     = be_mask & PERIPH_RST_IMPL & periph_cap_r;
		port_wmask       = be_mask & PORT_RST_IMPL & port_cap_r;
		periph_cap_wmask = be_mask & PERIPH_RST_IMPL;
		port_cap_wmask   = be_mask & PORT_RST_IMPL;
	end

	// Reserved bits read as zero whatever the flops hold
	assign periph_rd = periph_rst_r & PERIPH_RST_IMPL;
	assign port_rd   = port_rst_r & PORT_RST_IMPL;

	////////////////////////////////////////////////////////////////////////
	// Reset register next values; only the masked bits follow the data.
	// Reading a bit in the access that writes it returns the old value,
	// because the read is picked one edge before the write lands.
	always_comb begin
		periph_rst_nxt = periph_rst_r;
		port_rst_nxt   = port_rst_r;
		if (commit && hit_periph_rst) begin
			// Serial, quadrature, two-wire, counter, comparator bits
			periph_rst_nxt = (periph_rst_r & ~periph_wmask) | (writedata_in & periph_wmask);
		end
		if (commit && hit_port_rst) begin
			// Port A to port H, bit 0 to bit 7
			port_rst_nxt = (port_rst_r & ~port_wmask) | (writedata_in & port_wmask);
		end
	end

	// Reset registers clear at system reset; clock enable freezes them
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			periph_rst_r <= PERIPH_RST_INIT;
			port_rst_r   <= PORT_RST_INIT;
		end else if (clk_en_in) begin
			periph_rst_r <= periph_rst_nxt;
			port_rst_r   <= port_rst_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Capability masks; only implemented bits can ever be set, so a mask
	// never opens a reserved reset bit to writes
	always_comb begin
		periph_cap_nxt = periph_cap_r;
		port_cap_nxt   = port_cap_r;
		if (commit && hit_periph_cap) begin
			periph_cap_nxt = (periph_cap_r & ~periph_cap_wmask) | (writedata_in & periph_cap_wmask);
		end
		if (commit && hit_port_cap) begin
			port_cap_nxt = (port_cap_r & ~port_cap_wmask) | (writedata_in & port_cap_wmask);
		end
	end

	// Masks come out of reset with every implemented unit present
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			periph_cap_r <= PERIPH_CAP_INIT;
			port_cap_r   <= PORT_CAP_INIT;
		end else if (clk_en_in) begin
			periph_cap_r <= periph_cap_nxt;
			port_cap_r   <= port_cap_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus response next values; read data is picked in the wait cycle
	always_comb begin
		ack_nxt      = take;
		readdata_nxt = readdata_r;
		if (take && read_in) begin
			unique case (address_in)
				PERIPH_RST_OFS: readdata_nxt = periph_rd;
				PORT_RST_OFS:   readdata_nxt = port_rd;
				PERIPH_CAP_OFS: readdata_nxt = periph_cap_r;
				PORT_CAP_OFS:   readdata_nxt = port_cap_r;
				default:        readdata_nxt = UNMAPPED_DATA;
			endcase
		end
	end

	// Bus response flops; a stalled clock enable holds the wait state
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			readdata_r <= READDATA_INIT;
			ack_r      <= 1'b0;
		end else if (clk_en_in) begin
			readdata_r <= readdata_nxt;
			ack_r      <= ack_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bits drive peripheral resets directly, active high, from flops so a
	// reset line never glitches while the bus decodes an access
	assign readdata_out = readdata_r;

	// Serial unit resets
	assign async_serial_zero_reset_out    = periph_rst_r[ASYNC0_BIT];
	assign async_serial_one_reset_out     = periph_rst_r[ASYNC1_BIT];
	assign sync_serial_zero_reset_out     = periph_rst_r[SYNC0_BIT];
	assign sync_serial_one_reset_out      = periph_rst_r[SYNC1_BIT];

	// Quadrature and two-wire unit resets
	assign quadrature_unit_zero_reset_out = periph_rst_r[QUAD0_BIT];
	assign two_wire_zero_reset_out        = periph_rst_r[TWI0_BIT];

	// Counter and comparator groups, three bits each; counter bit 17 is reserved and stays zero
	assign gp_counter_reset_out           = periph_rst_r[GPT0_BIT +: 3];
	assign comparator_reset_out           = periph_rst_r[CMP0_BIT +: 3];

	// Port resets, port A on bit 0; the reserved upper bits never leave
	assign port_reset_out                 = port_rst_r[7:0];
endmodule
`default_nettype wire

/* File: verif/sw_reset_monitor.sv */
// Purpose: Bus timing and reset-output checks for the reset controller
// Assumes: Only the top-level ports are visible
// Notes:   Capability masks are not visible, so gating is checked by cause only
`timescale 1ns/10ps
`default_nettype none
module sw_reset_monitor
	import sw_reset_pkg::*;
(
	input wire logic              clk_in, rst_b_in, clk_en_in, read_in, write_in, waitrequest_out,
	input wire logic [ADDR_W-1:0] address_in,
	input wire logic [31:0]       writedata_in, readdata_out,
	input wire logic [3:0]        byteenable_in,
	input wire logic              async_serial_zero_reset_out, async_serial_one_reset_out, two_wire_zero_reset_out,
	input wire logic              sync_serial_zero_reset_out, sync_serial_one_reset_out, quadrature_unit_zero_reset_out,
	input wire logic [2:0]        gp_counter_reset_out, comparator_reset_out,
	input wire logic [7:0]        port_reset_out
);
	////////////////////////////////////////////////////////////////
	// Completed access, used as the cause of every register change
	wire        done = (read_in | write_in) & ~waitrequest_out & clk_en_in;
	wire [31:0] per  = {5'h0, comparator_reset_out, 5'h0, gp_counter_reset_out, 3'h0, two_wire_zero_reset_out,
		3'h0, quadrature_unit_zero_reset_out, 2'h0, sync_serial_one_reset_out, sync_serial_zero_reset_out,
		2'h0, async_serial_one_reset_out, async_serial_zero_reset_out};
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	AST_WAIT_FIRST: assert property ($rose(read_in | write_in) |-> waitrequest_out) else $error("no wait state");
	AST_ONE_WAIT: assert property ((read_in | write_in) && waitrequest_out && clk_en_in |=> !waitrequest_out)
		else $error("more than one wait state");
	AST_PORT_CAUSE: assert property ($changed(port_reset_out) |-> $past(write_in & done & address_in == PORT_RST_OFS))
		else $error("port bits changed without a write");
	AST_PORT_VAL: assert property ($changed(port_reset_out) |-> ((port_reset_out ^ $past(writedata_in[7:0]))
		& (port_reset_out ^ $past(port_reset_out))) == 8'h00) else $error("port bit took wrong value");
	AST_PER_CAUSE: assert property ($changed(per) |-> $past(write_in & done & address_in == PERIPH_RST_OFS))
		else $error("peripheral bits changed without a write");
	AST_QUAD: assert property ($changed(quadrature_unit_zero_reset_out) |-> quadrature_unit_zero_reset_out
		== $past(writedata_in[QUAD0_BIT])) else $error("quadrature bit wrong");
	AST_SYNC: assert property ($changed(sync_serial_one_reset_out) |-> sync_serial_one_reset_out
		== $past(writedata_in[SYNC1_BIT])) else $error("sync serial bit wrong");
	AST_ASYNC: assert property ($changed(async_serial_zero_reset_out) |-> async_serial_zero_reset_out
		== $past(writedata_in[ASYNC0_BIT])) else $error("async serial bit wrong");
	AST_PORT_RD: assert property (read_in && done && address_in == PORT_RST_OFS |-> readdata_out
		== {24'h0, port_reset_out}) else $error("port readback wrong");
	AST_PER_RD: assert property (read_in && done && address_in == PERIPH_RST_OFS |-> readdata_out == per)
		else $error("peripheral readback wrong");
	COV_PORT_WR: cover property (write_in && done && address_in == PORT_RST_OFS);
	COV_PER_RD: cover property (read_in && done && address_in == PERIPH_RST_OFS);
	COV_QUAD: cover property ($rose(quadrature_unit_zero_reset_out));
endmodule
bind peripheral_software_reset_ctrl sw_reset_monitor sw_reset_monitor_i (.*);
`default_nettype wire

/* File: verif/peripheral_software_reset_ctrl_tb.sv */
// Purpose: Directed bench for the peripheral software reset controller
// Assumes: Master waits up to 20 edges for waitrequest low, then ends the run
// Notes:   Capability mask narrowed once to show write gating
`timescale 1ns/10ps
`default_nettype none
module peripheral_software_reset_ctrl_tb
	import sw_reset_pkg::*;
;
	logic        clk_in = 1'b0, rst_b_in = 1'b0, read_in = 1'b0, write_in = 1'b0;
	logic        clk_en_in = 1'b1;
	logic [3:0]  byteenable_in = 4'hf;
	logic [11:0] address_in = 12'h000;
	logic [31:0] writedata_in = 32'h0, readdata_out, q;
	logic        waitrequest_out, as0, as1, ss0, ss1, qz, tw;
	logic [2:0]  gp, cmp;
	logic [7:0]  port;
	int          err_total = 0, total_checks = 0;
	wire  [31:0] per = {5'h0, cmp, 5'h0, gp, 3'h0, tw, 3'h0, qz, 2'h0, ss1, ss0, 2'h0, as1, as0};
	always #5 clk_in = ~clk_in;
	peripheral_software_reset_ctrl peripheral_software_reset_ctrl_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.clk_en_in(clk_en_in), .address_in(address_in), .read_in(read_in), .write_in(write_in),
		.writedata_in(writedata_in), .byteenable_in(byteenable_in), .readdata_out(readdata_out),
		.waitrequest_out(waitrequest_out), .async_serial_zero_reset_out(as0), .async_serial_one_reset_out(as1),
		.sync_serial_zero_reset_out(ss0), .sync_serial_one_reset_out(ss1), .quadrature_unit_zero_reset_out(qz),
		.two_wire_zero_reset_out(tw), .gp_counter_reset_out(gp), .comparator_reset_out(cmp), .port_reset_out(port));
	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Holds a raised request until waitrequest is seen low at a rising edge,
	// takes read data there, releases, and lets one edge pass so outputs settle
	task automatic finish_req(output logic [31:0] r);
		int n;
		n = 0;
		r = 32'h0;
		do begin
			@(posedge clk_in);
			n++;
		end while (waitrequest_out !== 1'b0 && n < 20);
		if (waitrequest_out !== 1'b0) begin
			err_total++;
			end_sim();
		end else begin
			r = readdata_out;
			read_in <= 1'b0;
			write_in <= 1'b0;
			@(posedge clk_in);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_in);
		read_in <= !w;
		write_in <= w;
		address_in <= a;
		writedata_in <= d;
		finish_req(r);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		bus(0, PORT_RST_OFS, 0, q); chk("port_init", q, PORT_RST_INIT);
		bus(0, PERIPH_RST_OFS, 0, q); chk("per_init", q, PERIPH_RST_INIT);
		chk("outs_init", per | {24'h0, port}, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_port();
		bus(1, PORT_RST_OFS, 32'hffff_ffff, q); bus(0, PORT_RST_OFS, 0, q);
		chk("port_rd", q, 32'h0000_00ff);
		chk("port_pins", {24'h0, port}, 32'h0000_00ff);
		bus(1, PORT_RST_OFS, 32'h1, q); chk("port_a", {24'h0, port}, 32'h1);
		$display("port test done");
	endtask
	task automatic t_gate();
		bus(1, PORT_CAP_OFS, 32'h0f, q); bus(1, PORT_RST_OFS, 32'hfe, q);
		chk("port_gated", {24'h0, port}, 32'h0e);
		bus(1, PORT_CAP_OFS, 32'hff, q);
		$display("gating test done");
	endtask
	// Disabled lane drops its bits; a frozen clock enable stalls the write
	task automatic t_lane_freeze();
		byteenable_in <= 4'he;
		bus(1, PORT_RST_OFS, 32'h0000_00f1, q);
		chk("lane_off", {24'h0, port}, 32'h0000_000e);
		@(posedge clk_in);
		byteenable_in <= 4'hf;
		clk_en_in <= 1'b0;
		write_in <= 1'b1;
		address_in <= PORT_RST_OFS;
		writedata_in <= 32'h0;
		repeat (4) @(posedge clk_in);
		chk("frozen_wait", {31'h0, waitrequest_out}, 32'h1);
		chk("frozen_bits", {24'h0, port}, 32'h0000_000e);
		clk_en_in <= 1'b1;
		finish_req(q);
		chk("thawed_bits", {24'h0, port}, 32'h0);
		$display("lane and freeze test done");
	endtask
	// Reset in mid-run clears bits that are set
	task automatic t_rerst();
		bus(1, PORT_RST_OFS, 32'h0000_00ff, q);
		bus(1, PERIPH_RST_OFS, 32'hffff_ffff, q);
		chk("pre_rst", per | {24'h0, port}, PERIPH_RST_IMPL | PORT_RST_IMPL);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		chk("rst_outs", per | {24'h0, port}, 32'h0);
		rst_b_in <= 1'b1;
		bus(0, PORT_RST_OFS, 0, q);
		chk("rst_port", q, PORT_RST_INIT);
		$display("mid-run reset test done");
	endtask
	task automatic t_periph();
		bus(1, PERIPH_RST_OFS, 32'hffff_ffff, q); bus(0, PERIPH_RST_OFS, 0, q);
		chk("per_rd", q, PERIPH_RST_IMPL);
		chk("per_pins", per, PERIPH_RST_IMPL);
		bus(1, PERIPH_RST_OFS, 32'h0, q); chk("per_clear", per, 32'h0);
		bus(0, 12'h200, 0, q); chk("unmapped", q, UNMAPPED_DATA);
		bus(1, 12'h200, 32'hffff_ffff, q); chk("unmapped_wr", per | {24'h0, port}, 32'h0);
		$display("peripheral test done");
	endtask
	initial begin
		repeat (20) @(posedge clk_in);
		rst_b_in <= 1'b1;
		t_reset();
		t_port();
		t_gate();
		t_lane_freeze();
		t_periph();
		t_rerst();
		end_sim();
	end
endmodule
`default_nettype wire
